/* File: hw/wpm_pkg.sv */
/*
 * Constants, field layouts and types for the wake, power and misc register page.
 * Assumes a single core clock domain and a host on a plain strobe register port.
 */
// Notes on behaviour
// RULE1: Link change flag bit6, cleared by power write/one
// RULE2: Wake frame flag bit5, same clearing
// RULE3: Signature packet flag bit4, same clearing
// RULE4: Three wake enables bits 2..0, reset zero
// RULE5: Regulator standby bit4 of power register
// RULE6: Power state field bits 1:0 encoding
// RULE7: Power state clears itself on wake-up
// RULE8: First saving state keeps wake detection active
// RULE9: Deeper state left only by wake or power register write
// RULE10: Host never programs reserved power state
// RULE11: Reload bit starts EEPROM reload, self-clears
// RULE12: Misc bit2 enables general purpose timer
// RULE13: Misc bit1 selects burst address bit
// RULE14: Ring bit zero: DMA writes anywhere
// RULE15: Ring bit one: wrap 40h to start-1
// RULE16: Timer bytes at 0Eh/0Fh, reset FFh
// RULE17: Only enabled sources wake; flags stay set
// RULE18: Data port 16-bit, consecutive DMA words
package wpm_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Register offsets
    localparam logic [4:0] OFF_WAKE_CTRL  = 5'h0a;
    localparam logic [4:0] OFF_POWER      = 5'h0b;
    localparam logic [4:0] OFF_RELOAD     = 5'h0c;
    localparam logic [4:0] OFF_MISC       = 5'h0d;
    localparam logic [4:0] OFF_TIMER_LO   = 5'h0e;
    localparam logic [4:0] OFF_TIMER_HI   = 5'h0f;
    localparam logic [4:0] OFF_DATA_PORT  = 5'h10;
    localparam logic [4:0] OFF_IRQ_STATUS = 5'h1a;
    localparam logic [4:0] OFF_IRQ_MASK   = 5'h1b;
    localparam logic [4:0] OFF_DMA_LO     = 5'h1c;
    localparam logic [4:0] OFF_DMA_HI     = 5'h1d;
    localparam logic [4:0] OFF_HOST_WAKE  = 5'h1f;

    ////////////////////////////////////////////////////////////////////////////
    // Field positions
    localparam int BIT_LINK_FLAG    = 6;
    localparam int BIT_FRAME_FLAG   = 5;
    localparam int BIT_SIG_FLAG     = 4;
    localparam int BIT_LINK_EN      = 2;
    localparam int BIT_FRAME_EN     = 1;
    localparam int BIT_SIG_EN       = 0;
    localparam int BIT_REG_STANDBY  = 4;
    localparam int BIT_RELOAD       = 0;
    localparam int BIT_TIMER_EN     = 2;
    localparam int BIT_BURST_SEL    = 1;
    localparam int BIT_TX_RING      = 0;
    localparam int NUM_IRQ          = 4;
    localparam int IRQ_LINK         = 0;
    localparam int IRQ_FRAME        = 1;
    localparam int IRQ_SIG          = 2;
    localparam int IRQ_WAKE         = 3;

    ////////////////////////////////////////////////////////////////////////////
    // Reset values and memory constants
    localparam logic [7:0]  RST_ZERO8     = 8'h00;
    localparam logic [7:0]  RST_TIMER     = 8'hff;
    localparam logic [15:0] RST_ZERO16    = 16'h0000;
    localparam logic [7:0]  RING_BASE_PG  = 8'h40;
    localparam logic [15:0] DMA_STEP      = 16'h0002;

    ////////////////////////////////////////////////////////////////////////////
    // Power state field encoding: normal, first saving, deeper saving, reserved
    typedef enum logic [1:0] {
        PWR_NORMAL,
        PWR_LIGHT,
        PWR_DEEP,
        PWR_RSVD
    } wpm_pwr_t;

endpackage

/* File: hw/wpm_mem_if.sv */
/*
 * Port bundle between the register page and its packet memory.
 * Assumes one clock; read data registered one cycle after the address.
 */
`timescale 1ns/1ps
interface wpm_mem_if #(
    parameter int AW = 13,
    parameter int DW = 16
);
    logic          we;
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
    logic [DW-1:0] rdata;

    modport ctrl (output we, output addr, output wdata, input rdata);
    modport mem  (input we, input addr, input wdata, output rdata);
endinterface

/* File: hw/wpm_pkt_mem.sv */
/*
 * Single port packet memory with registered read data.
 * Assumes the controller supplies address and write strobe on core_clk.
 */
`timescale 1ns/1ps
module wpm_pkt_mem #(
    parameter int AW = 13,
    parameter int DW = 16
) (
    // Clock
    input wire logic core_clk,
    // Memory port
    wpm_mem_if.mem   port
);

    logic [DW-1:0] mem_q [2**AW];
    logic [DW-1:0] rdata_q;

    // Read during write returns the old word
    always_ff @(posedge core_clk) begin
        if (port.we) begin
            mem_q[port.addr] <= port.wdata;
        end
        rdata_q <= mem_q[port.addr];
    end

    assign port.rdata = rdata_q;

endmodule

/* File: hw/wpm_regs.sv */
/*
 * Wake-up, power state, EEPROM reload, misc control, timer and data port page.
 * Assumes wake events are one-cycle pulses on core_clk from the wake detector,
 * and the host drives one-cycle strobes on the register port.
 */
// The implementer's own choice: the strobed register port.
`timescale 1ns/1ps
module wpm_regs #(
    parameter int MEM_AW = 13
) (
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        reset_n,
    // Register port
    input  wire logic [4:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [15:0] reg_rdata,
    // Wake event pulses from the detector
    input  wire logic        link_change_evt,
    input  wire logic        frame_wake_evt,
    input  wire logic        signature_evt,
    // Receive ring start page from the MAC page registers
    input  wire logic [7:0]  receive_start_page,
    // Control outputs
    output logic [1:0]       power_state_field,
    output logic             regulator_standby,
    output logic             wake_detect_active,
    output logic             wake_up,
    output logic             eeprom_reload_start,
    output logic             timer_enable_bit,
    output logic             burst_address_select,
    output logic [15:0]      timer_value,
    output logic             irq
);

    ////////////////////////////////////////////////////////////////////////////
    // State

    logic [2:0]                   flags_q, flags_d;     // Link, frame, signature
    logic [2:0]                   wake_en_q, wake_en_d;
    wpm_pkg::wpm_pwr_t            pwr_q, pwr_d;
    logic                         standby_q, standby_d;
    logic                         reload_q, reload_d;
    logic                         timer_en_q, timer_en_d;
    logic                         burst_sel_q, burst_sel_d;
    logic                         ring_q, ring_d;
    logic [7:0]                   timer_lo_q, timer_lo_d;
    logic [7:0]                   timer_hi_q, timer_hi_d;
    logic [15:0]                  dma_q, dma_d;
    logic [15:0]                  rdata_q, rdata_d;
    logic [wpm_pkg::NUM_IRQ-1:0]  ist_q, ist_d;
    logic [wpm_pkg::NUM_IRQ-1:0]  imask_q, imask_d;
    logic                         irq_q, irq_d;
    logic                         wake_q, wake_d;
    logic                         detect_q;

    logic [2:0]                   evt;
    logic [2:0]                   wake_hit;
    logic [15:0]                  dma_next;

    wpm_mem_if #(.AW(MEM_AW), .DW(16)) mem_bus ();

    ////////////////////////////////////////////////////////////////////////////
    // Packet memory

    wpm_pkt_mem #(
        .AW (MEM_AW),
        .DW (16)
    ) u_mem (
        .core_clk (core_clk),
        .port     (mem_bus.mem)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Event vector in flag order

    assign evt = {link_change_evt, frame_wake_evt, signature_evt};

    // Wake qualification; detection runs only in light saving
    for (genvar i = 0; i < 3; i++) begin : g_wake
        assign wake_hit[i] = evt[i] && wake_en_q[i] && (pwr_q == wpm_pkg::PWR_LIGHT); // RULE17 RULE8
    end

    // Next DMA address, wrapping in the transmit ring
    always_comb begin
        dma_next = dma_q + wpm_pkg::DMA_STEP;
        if (ring_q && (dma_next[15:8] >= receive_start_page)) begin
            dma_next = {wpm_pkg::RING_BASE_PG, wpm_pkg::RST_ZERO8};      // RULE15
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Next value logic for the whole page

    always_comb begin
        flags_d     = flags_q;
        wake_en_d   = wake_en_q;
        pwr_d       = pwr_q;
        standby_d   = standby_q;
        reload_d    = 1'b0;                                          // RULE11
        timer_en_d  = timer_en_q;
        burst_sel_d = burst_sel_q;
        ring_d      = ring_q;
        timer_lo_d  = timer_lo_q;
        timer_hi_d  = timer_hi_q;
        dma_d       = dma_q;
        rdata_d     = wpm_pkg::RST_ZERO16;
        ist_d       = ist_q;
        imask_d     = imask_q;
        wake_d      = 1'b0;

        // Host writes
        if (reg_wr) begin
            case (reg_addr)
                wpm_pkg::OFF_WAKE_CTRL: begin
                    // Write one to clear each flag
                    flags_d = flags_q & ~{reg_wdata[wpm_pkg::BIT_LINK_FLAG],
                                          reg_wdata[wpm_pkg::BIT_FRAME_FLAG],
                                          reg_wdata[wpm_pkg::BIT_SIG_FLAG]}; // RULE1 RULE2 RULE3
                    wake_en_d = {reg_wdata[wpm_pkg::BIT_LINK_EN],
                                 reg_wdata[wpm_pkg::BIT_FRAME_EN],
                                 reg_wdata[wpm_pkg::BIT_SIG_EN]};            // RULE4
                end
                wpm_pkg::OFF_POWER: begin
                    flags_d   = '0;                                  // RULE1 RULE2 RULE3
                    standby_d = reg_wdata[wpm_pkg::BIT_REG_STANDBY]; // RULE5
                    pwr_d     = wpm_pkg::wpm_pwr_t'(reg_wdata[1:0]); // RULE6
                end
                wpm_pkg::OFF_RELOAD: begin
                    reload_d = reg_wdata[wpm_pkg::BIT_RELOAD];       // RULE11
                end
                wpm_pkg::OFF_MISC: begin
                    timer_en_d  = reg_wdata[wpm_pkg::BIT_TIMER_EN];  // RULE12
                    burst_sel_d = reg_wdata[wpm_pkg::BIT_BURST_SEL]; // RULE13
                    ring_d      = reg_wdata[wpm_pkg::BIT_TX_RING];   // RULE14 RULE15
                end
                wpm_pkg::OFF_TIMER_LO: timer_lo_d = reg_wdata[7:0];  // RULE16
                wpm_pkg::OFF_TIMER_HI: timer_hi_d = reg_wdata[7:0];  // RULE16
                wpm_pkg::OFF_DATA_PORT: begin
                    // Ring off: plain increment
                    dma_d = ring_q ? dma_next : (dma_q + wpm_pkg::DMA_STEP); // RULE14 RULE18
                end
                wpm_pkg::OFF_IRQ_MASK: imask_d = reg_wdata[wpm_pkg::NUM_IRQ-1:0];
                wpm_pkg::OFF_DMA_LO:   dma_d   = {dma_q[15:8], reg_wdata[7:0]};
                wpm_pkg::OFF_DMA_HI:   dma_d   = {reg_wdata[7:0], dma_q[7:0]};
                wpm_pkg::OFF_HOST_WAKE: begin
                    // One way out of the deep state; a power register write is the other
                    if (pwr_q == wpm_pkg::PWR_DEEP) begin
                        pwr_d  = wpm_pkg::PWR_NORMAL;                // RULE9
                        wake_d = 1'b1;
                    end
                end
                default: ;
            endcase
        end

        // Host reads; data stand in the following cycle only
        if (reg_rd) begin
            case (reg_addr)
                wpm_pkg::OFF_WAKE_CTRL: begin
                    rdata_d[wpm_pkg::BIT_LINK_FLAG]  = flags_q[2];
                    rdata_d[wpm_pkg::BIT_FRAME_FLAG] = flags_q[1];
                    rdata_d[wpm_pkg::BIT_SIG_FLAG]   = flags_q[0];
                    rdata_d[wpm_pkg::BIT_LINK_EN]    = wake_en_q[2];
                    rdata_d[wpm_pkg::BIT_FRAME_EN]   = wake_en_q[1];
                    rdata_d[wpm_pkg::BIT_SIG_EN]     = wake_en_q[0];
                end
                wpm_pkg::OFF_POWER: begin
                    rdata_d[wpm_pkg::BIT_REG_STANDBY] = standby_q;
                    rdata_d[1:0]                      = pwr_q;
                end
                wpm_pkg::OFF_MISC: begin
                    rdata_d[wpm_pkg::BIT_TIMER_EN]  = timer_en_q;
                    rdata_d[wpm_pkg::BIT_BURST_SEL] = burst_sel_q;
                    rdata_d[wpm_pkg::BIT_TX_RING]   = ring_q;
                end
                wpm_pkg::OFF_TIMER_LO:  rdata_d[7:0] = timer_lo_q;     // RULE16
                wpm_pkg::OFF_TIMER_HI:  rdata_d[7:0] = timer_hi_q;     // RULE16
                wpm_pkg::OFF_DATA_PORT: begin
                    // Prefetched word at the DMA address
                    rdata_d = mem_bus.rdata;                            // RULE18
                    dma_d   = dma_q + wpm_pkg::DMA_STEP;                // RULE18
                end
                wpm_pkg::OFF_IRQ_STATUS: begin
                    rdata_d[wpm_pkg::NUM_IRQ-1:0] = ist_q;
                    ist_d = '0;
                end
                wpm_pkg::OFF_IRQ_MASK:  rdata_d[wpm_pkg::NUM_IRQ-1:0] = imask_q;
                wpm_pkg::OFF_DMA_LO:    rdata_d[7:0] = dma_q[7:0];
                wpm_pkg::OFF_DMA_HI:    rdata_d[7:0] = dma_q[15:8];
                default: ;
            endcase
        end

        // Events set flags last so a same cycle clear cannot lose them
        flags_d = flags_d | evt;                                    // RULE1 RULE2 RULE3 RULE17
        if (|wake_hit) begin
            pwr_d  = wpm_pkg::PWR_NORMAL;                           // RULE7
            wake_d = 1'b1;
        end

        // Sticky interrupt status; set wins over the read clear
        ist_d[wpm_pkg::IRQ_LINK]  = ist_d[wpm_pkg::IRQ_LINK]  | evt[2];
        ist_d[wpm_pkg::IRQ_FRAME] = ist_d[wpm_pkg::IRQ_FRAME] | evt[1];
        ist_d[wpm_pkg::IRQ_SIG]   = ist_d[wpm_pkg::IRQ_SIG]   | evt[0];
        ist_d[wpm_pkg::IRQ_WAKE]  = ist_d[wpm_pkg::IRQ_WAKE]  | wake_d;
        irq_d = |(ist_d & imask_d);
    end

    ////////////////////////////////////////////////////////////////////////////
    // Memory port: prefetch at the next DMA pointer

    assign mem_bus.we    = reg_wr && (reg_addr == wpm_pkg::OFF_DATA_PORT);
    assign mem_bus.wdata = reg_wdata;
    // Write uses the current pointer, otherwise prefetch the next one
    assign mem_bus.addr  = mem_bus.we ? dma_q[MEM_AW:1] : dma_d[MEM_AW:1];

    ////////////////////////////////////////////////////////////////////////////
    // Registers

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            flags_q     <= '0;
            wake_en_q   <= '0;                                       // RULE4
            pwr_q       <= wpm_pkg::PWR_NORMAL;                      // RULE6
            standby_q   <= 1'b0;                                     // RULE5
            reload_q    <= 1'b0;
            timer_en_q  <= 1'b0;                                     // RULE12
            burst_sel_q <= 1'b0;                                     // RULE13
            ring_q      <= 1'b0;                                     // RULE14
            timer_lo_q  <= wpm_pkg::RST_TIMER;                       // RULE16
            timer_hi_q  <= wpm_pkg::RST_TIMER;                       // RULE16
            dma_q       <= wpm_pkg::RST_ZERO16;
            rdata_q     <= wpm_pkg::RST_ZERO16;
            ist_q       <= '0;
            imask_q     <= '0;
            irq_q       <= 1'b0;
            wake_q      <= 1'b0;
            detect_q    <= 1'b0;
        end else begin
            flags_q     <= flags_d;
            wake_en_q   <= wake_en_d;
            pwr_q       <= pwr_d;
            standby_q   <= standby_d;
            reload_q    <= reload_d;
            timer_en_q  <= timer_en_d;
            burst_sel_q <= burst_sel_d;
            ring_q      <= ring_d;
            timer_lo_q  <= timer_lo_d;
            timer_hi_q  <= timer_hi_d;
            dma_q       <= dma_d;
            rdata_q     <= rdata_d;
            ist_q       <= ist_d;
            imask_q     <= imask_d;
            irq_q       <= irq_d;
            wake_q      <= wake_d;
            detect_q    <= (pwr_d == wpm_pkg::PWR_LIGHT);            // RULE8
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs, all straight from flip-flops

    assign reg_rdata            = rdata_q;
    assign power_state_field    = pwr_q;
    assign regulator_standby    = standby_q;
    assign wake_detect_active   = detect_q;
    assign wake_up              = wake_q;
    assign eeprom_reload_start  = reload_q;
    assign timer_enable_bit     = timer_en_q;
    assign burst_address_select = burst_sel_q;
    assign timer_value          = {timer_hi_q, timer_lo_q};
    assign irq                  = irq_q;

endmodule

/* File: bench/wpm_regs_chk.sv */
/* Port checker for wpm_regs. Assumes it is bound onto the register page top. */
`timescale 1ns/1ps
module wpm_regs_chk (
    // Clock, reset and host port
    input wire logic        core_clk,
    input wire logic        reset_n,
    input wire logic [4:0]  reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [15:0] reg_rdata,
    // Control outputs
    input wire logic [1:0]  power_state_field,
    input wire logic        regulator_standby,
    input wire logic        wake_detect_active,
    input wire logic        wake_up,
    input wire logic        eeprom_reload_start,
    input wire logic        timer_enable_bit,
    input wire logic        burst_address_select,
    input wire logic [15:0] timer_value
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    ////////////////////////////////////////////////////////////////////////////
    // Write decodes
    logic w_pwr, w_host, w_rld, w_misc, w_tlo, w_thi;
    assign w_pwr  = reg_wr && reg_addr == wpm_pkg::OFF_POWER;
    assign w_host = reg_wr && reg_addr == wpm_pkg::OFF_HOST_WAKE;
    assign w_rld  = reg_wr && reg_addr == wpm_pkg::OFF_RELOAD;
    assign w_misc = reg_wr && reg_addr == wpm_pkg::OFF_MISC;
    assign w_tlo  = reg_wr && reg_addr == wpm_pkg::OFF_TIMER_LO;
    assign w_thi  = reg_wr && reg_addr == wpm_pkg::OFF_TIMER_HI;
    ////////////////////////////////////////////////////////////////////////////
    property p_rd_idle; !reg_rd |=> reg_rdata == 16'h0000; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
    property p_pwr_wr;
        w_pwr |=> power_state_field == $past(reg_wdata[1:0])
              && regulator_standby == $past(reg_wdata[4]);
    endproperty
    a_pwr_wr: assert property (p_pwr_wr) else $error("power write lost");
    property p_wake_norm; wake_up |-> power_state_field == 2'b00 ##1 !wake_up; endproperty
    a_wake_norm: assert property (p_wake_norm) else $error("wake left state");
    property p_wake_src; wake_up |-> $past(power_state_field) != 2'b00; endproperty
    a_wake_src: assert property (p_wake_src) else $error("wake from normal");
    property p_detect; wake_detect_active == (power_state_field == 2'b01); endproperty
    a_detect: assert property (p_detect) else $error("detect flag wrong");
    property p_deep_hold;
        power_state_field == 2'b10 && !w_pwr && !w_host |=> power_state_field == 2'b10;
    endproperty
    a_deep_hold: assert property (p_deep_hold) else $error("deep state left");
    property p_host_wake;
        power_state_field == 2'b10 && w_host |=> power_state_field == 2'b00 && wake_up;
    endproperty
    a_host_wake: assert property (p_host_wake) else $error("host wake lost");
    property p_reload;
        w_rld && reg_wdata[0] |=> eeprom_reload_start ##1 !eeprom_reload_start;
    endproperty
    a_reload: assert property (p_reload) else $error("reload pulse wrong");
    property p_misc;
        w_misc |=> {timer_enable_bit, burst_address_select} == $past(reg_wdata[2:1]);
    endproperty
    a_misc: assert property (p_misc) else $error("misc bits wrong");
    property p_tlo;
        w_tlo |=> timer_value[7:0] == $past(reg_wdata[7:0]) && $stable(timer_value[15:8]);
    endproperty
    a_tlo: assert property (p_tlo) else $error("timer low wrong");
    property p_thi; w_thi |=> timer_value[15:8] == $past(reg_wdata[7:0]); endproperty
    a_thi: assert property (p_thi) else $error("timer high wrong");
    // Main scenarios reached
    c_light: cover property (power_state_field == 2'b01 ##1 wake_up);
    c_host: cover property (w_host ##1 wake_up);
    c_reload: cover property (eeprom_reload_start);
endmodule
bind wpm_regs wpm_regs_chk i_chk (.*);

/* File: bench/wpm_host_model.sv */
/* Host model on the strobe register port. Assumes callers start after a clock edge. */
`timescale 1ns/1ps
module wpm_host_model (
    // Clock and read data
    input  wire logic        core_clk,
    input  wire logic [15:0] reg_rdata,
    // Register port drive
    output logic      [4:0]  reg_addr,
    output logic      [15:0] reg_wdata,
    output logic             reg_wr,
    output logic             reg_rd
);
    // Idle bus at time zero
    initial begin
        reg_addr  = 5'h00;
        reg_wdata = 16'h0000;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
    end
    // One-cycle write
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        if (a == wpm_pkg::OFF_POWER && d[1:0] == 2'b11) d[1:0] = 2'b00;
        @(posedge core_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge core_clk);
        reg_wr    <= 1'b0;
        #1;
    endtask
    // One-cycle read, data taken next cycle
    task automatic rd(input logic [4:0] a, output logic [15:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge core_clk);
        reg_rd   <= 1'b0;
        #1;
        d = reg_rdata;
    endtask
    // Leaves the deep state
    task automatic host_wake();
        wr(wpm_pkg::OFF_HOST_WAKE, 16'h0000);
    endtask
endmodule

/* File: bench/tb_wpm_regs.sv */
/* Self-checking bench for wpm_regs. Assumes the host model drives the register port. */
`timescale 1ns/1ps
module tb_wpm_regs;
    // Clock, reset, detector pulses {link, frame, signature}
    logic        core_clk, reset_n, reg_wr, reg_rd, regulator_standby, wake_detect_active;
    logic        wake_up, eeprom_reload_start, timer_enable_bit, burst_address_select, irq;
    logic [2:0]  evt;
    logic [7:0]  start_pg;
    logic [4:0]  reg_addr;
    logic [1:0]  power_state_field;
    logic [15:0] reg_wdata, reg_rdata, timer_value, d, lfsr_q, wq [3];
    int          num_errors = 0, n_compared = 0, cycles = 0;
    logic [4:0]  ra [7] = '{5'h0a, 5'h0b, 5'h0d, 5'h0e, 5'h0f, 5'h0c, 5'h05};
    logic [7:0]  rv [7] = '{8'h00, 8'h00, 8'h00, 8'hff, 8'hff, 8'h00, 8'h00};
    wpm_regs i_dut (.*, .link_change_evt(evt[2]), .frame_wake_evt(evt[1]),
                    .signature_evt(evt[0]), .receive_start_page(start_pg));
    wpm_host_model i_host (.*);
    ////////////////////////////////////////////////////////////////////////////
    // Helpers and expectations
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic rchk(input logic [4:0] a, input logic [15:0] exp);
        logic [15:0] v;
        i_host.rd(a, v);
        chk(v, exp);
    endtask
    task automatic pulse(input logic [2:0] m);
        @(posedge core_clk);
        evt <= m;
        @(posedge core_clk);
        evt <= 3'h0;
        #1;
    endtask
    task automatic tick();
        @(posedge core_clk);
        #1;
    endtask
    task automatic set_dma(input logic [15:0] a);
        i_host.wr(wpm_pkg::OFF_DMA_LO, {8'h00, a[7:0]});
        i_host.wr(wpm_pkg::OFF_DMA_HI, {8'h00, a[15:8]});
    endtask
    function automatic logic [15:0] wcs(input logic [2:0] f, input logic [2:0] e);
        return {9'h000, f, 1'b0, e};
    endfunction
    // Ring pointer step
    function automatic logic [15:0] ring_next(input logic [15:0] a, input logic r,
                                              input logic [7:0] pg);
        logic [15:0] n;
        n = a + 16'h0002;
        if (r && n[15:8] >= pg) n = {wpm_pkg::RING_BASE_PG, 8'h00};
        return n;
    endfunction
    function automatic logic [15:0] lfsr_next(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction
    task automatic close_out();
        $display("errors %0d compared %0d", num_errors, n_compared);
        if (num_errors == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // Clock and hang guard
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 5000) begin
            num_errors++;
            close_out();
        end
    end
    // Main sequence
    initial begin
        reset_n = 1'b0;
        evt = 3'h0;
        start_pg = 8'h42;
        lfsr_q = 16'hc767;
        repeat (5) @(posedge core_clk);
        reset_n <= 1'b1;
        chk(timer_value, 16'hffff);
        foreach (ra[i]) rchk(ra[i], {8'h00, rv[i]});
        repeat (4) begin
            lfsr_q = lfsr_next(lfsr_q);
            i_host.wr(wpm_pkg::OFF_TIMER_LO, {8'h00, lfsr_q[7:0]});
            i_host.wr(wpm_pkg::OFF_TIMER_HI, {8'h00, lfsr_q[15:8]});
            i_host.wr(wpm_pkg::OFF_MISC, lfsr_q & 16'h0006);
            chk(timer_value, lfsr_q);
            rchk(wpm_pkg::OFF_TIMER_HI, {8'h00, lfsr_q[15:8]});
            chk({14'h0, timer_enable_bit, burst_address_select}, {14'h0, lfsr_q[2:1]});
        end
        // Light saving: only the enabled link source wakes
        i_host.wr(wpm_pkg::OFF_WAKE_CTRL, 16'h0004);
        i_host.wr(wpm_pkg::OFF_POWER, 16'h0001);
        chk(16'(wake_detect_active), 16'h0001);
        pulse(3'b010);
        chk({13'h0, wake_up, power_state_field}, 16'h0001);
        pulse(3'b100);
        chk({13'h0, wake_up, power_state_field}, 16'h0004);
        rchk(wpm_pkg::OFF_WAKE_CTRL, wcs(3'b110, 3'b100));
        i_host.wr(wpm_pkg::OFF_WAKE_CTRL, wcs(3'b010, 3'b100));
        rchk(wpm_pkg::OFF_WAKE_CTRL, wcs(3'b100, 3'b100));
        i_host.wr(wpm_pkg::OFF_POWER, 16'h0000);
        rchk(wpm_pkg::OFF_WAKE_CTRL, wcs(3'b000, 3'b100));
        pulse(3'b001);
        rchk(wpm_pkg::OFF_WAKE_CTRL, wcs(3'b001, 3'b100));
        i_host.wr(wpm_pkg::OFF_WAKE_CTRL, wcs(3'b001, 3'b100));
        rchk(wpm_pkg::OFF_WAKE_CTRL, wcs(3'b000, 3'b100));
        // Deep state ignores events until host wake
        i_host.wr(wpm_pkg::OFF_POWER, 16'h0002);
        pulse(3'b111);
        chk({14'h0, power_state_field}, 16'h0002);
        i_host.host_wake();
        chk({13'h0, wake_up, power_state_field}, 16'h0004);
        i_host.wr(wpm_pkg::OFF_POWER, 16'h0013);
        chk({11'h0, regulator_standby, 2'h0, power_state_field}, 16'h0010);
        i_host.wr(wpm_pkg::OFF_RELOAD, 16'h0001);
        chk(16'(eeprom_reload_start), 16'h0001);
        tick();
        chk(16'(eeprom_reload_start), 16'h0000);
        // Interrupt raised, cleared by read, then masked
        i_host.rd(wpm_pkg::OFF_IRQ_STATUS, d);
        for (int k = 1; k >= 0; k--) begin
            i_host.wr(wpm_pkg::OFF_IRQ_MASK, 16'(k));
            pulse(3'b100);
            tick();
            chk(16'(irq), 16'(k));
            rchk(wpm_pkg::OFF_IRQ_STATUS, 16'h0001);
            tick();
            chk(16'(irq), 16'h0000);
        end
        // Pointer step across the start page, ring off then on
        for (int k = 0; k < 2; k++) begin
            i_host.wr(wpm_pkg::OFF_MISC, 16'(k));
            set_dma(16'h4000);
            i_host.wr(wpm_pkg::OFF_DATA_PORT, 16'h1111);
            set_dma(16'h41fe);
            i_host.wr(wpm_pkg::OFF_DATA_PORT, 16'h2222);
            i_host.wr(wpm_pkg::OFF_DATA_PORT, 16'h4444);
            set_dma(16'h4000);
            d = (ring_next(16'h41fe, k[0], start_pg) == 16'h4000) ? 16'h4444 : 16'h1111;
            rchk(wpm_pkg::OFF_DATA_PORT, d);
        end
        set_dma(16'h0100);
        for (int k = 0; k < 3; k++) begin
            lfsr_q = lfsr_next(lfsr_q);
            wq[k] = lfsr_q;
            i_host.wr(wpm_pkg::OFF_DATA_PORT, lfsr_q);
        end
        set_dma(16'h0100);
        for (int k = 0; k < 3; k++) rchk(wpm_pkg::OFF_DATA_PORT, wq[k]);
        close_out();
    end
endmodule
